// >>> logic/ilo_pkg.sv
// Package: constants for the indexed literal offset operand address generator
package ilo_pkg;
    localparam int ADDR_W = 12;
    localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ADD_PREFIX = 4'h2;
    localparam logic [1:0] ADD_SUBOP = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
endpackage

// >>> logic/ilo_alu.sv
// Byte adder producing the result and the arithmetic status flags
module ilo_alu (
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    output logic [7:0] sum,
    output logic [4:0] flags
);
    logic [8:0] full;
    logic [4:0] low;
    always_comb begin
        full = {1'b0, opA} + {1'b0, opB};
        low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
        sum = full[7:0];
        flags = '0;
        flags[ilo_pkg::FLAG_C] = full[8];
        flags[ilo_pkg::FLAG_DC] = low[4];
        flags[ilo_pkg::FLAG_Z] = (full[7:0] == 8'h00);
        flags[ilo_pkg::FLAG_OV] = (opA[7] == opB[7]) && (full[7] != opA[7]);
        flags[ilo_pkg::FLAG_N] = full[7];
    end
endmodule

// >>> logic/ilo_addr_gen.sv
// Operand address generator for byte and bit instructions, with indexed literal offset mode
// Contract
// - Extension off: access bit picks access/banked address
// - Extension on, a=0, arg<=5Fh: pointer plus offset
// - Remap applies to all byte/bit instructions
// - Pointer zero gives original access mapping
// - Offset form always uses cleared access bit
// - Destination bit keeps accumulator/memory meaning
// - Indexed add updates N, OV, C, DC, Z
module ilo_addr_gen (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic extEnable,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [3:0] bankSelector,
    input wire logic [11:0] indirectPointerTwo,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] memReadData,
    output logic addrValid,
    output logic [11:0] operandAddr,
    output logic indexedUsed,
    output logic destMemory,
    output logic addValid,
    output logic [7:0] addResult,
    output logic [4:0] statusFlags,
    output logic [11:0] addWriteAddr
);
    typedef struct packed {
        logic addrValid;
        logic [11:0] operandAddr;
        logic indexedUsed;
        logic destMemory;
        logic addPending;
        logic addValid;
        logic [7:0] addResult;
        logic [4:0] statusFlags;
        logic [11:0] addWriteAddr;
    } ilo_state_t;

    ilo_state_t stQ, stD;
    logic [7:0] litArg;
    logic accessBit;
    logic offsetForm;
    logic isAddIndexed;
    logic [7:0] aluSum;
    logic [4:0] aluFlags;

    assign litArg = instrWord[7:0];
    assign accessBit = instrWord[8];
    // Every byte/bit opcode carries the access bit at bit 8, so the same path serves all of them
    assign offsetForm = extEnable && !accessBit && (litArg <= ilo_pkg::OFFSET_LIMIT);
    assign isAddIndexed = (instrWord[15:12] == ilo_pkg::ADD_PREFIX)
        && (instrWord[11:10] == ilo_pkg::ADD_SUBOP) && offsetForm;

    ilo_alu uAlu (
        .opA(accumulator),
        .opB(memReadData),
        .sum(aluSum),
        .flags(aluFlags)
    );

    always_comb begin
        stD = stQ;
        stD.addrValid = instrValid;
        stD.addValid = 1'b0;
        if (instrValid) begin
            stD.indexedUsed = offsetForm;
            stD.destMemory = instrWord[9];
            if (offsetForm) begin
                // Pointer zero returns offsets to their legacy access RAM locations
                stD.operandAddr = indirectPointerTwo + {4'h0, litArg};
            end else if (accessBit) begin
                stD.operandAddr = {bankSelector, litArg};
            end else if (litArg < ilo_pkg::ACCESS_SPLIT) begin
                stD.operandAddr = {4'h0, litArg};
            end else begin
                stD.operandAddr = {ilo_pkg::ACCESS_HIGH_BANK, litArg};
            end
        end
        // Memory read data is expected in the same cycle the address is issued
        stD.addPending = instrValid && isAddIndexed;
        if (stQ.addPending) begin
            stD.addValid = 1'b1;
            stD.addResult = aluSum;
            stD.statusFlags = aluFlags;
            stD.addWriteAddr = stQ.operandAddr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stQ <= '{addrValid: 1'b0, operandAddr: ilo_pkg::ADDR_RESET, indexedUsed: 1'b0,
                destMemory: 1'b0, addPending: 1'b0, addValid: 1'b0, addResult: ilo_pkg::DATA_RESET,
                statusFlags: ilo_pkg::FLAGS_RESET, addWriteAddr: ilo_pkg::ADDR_RESET};
        end else begin
            stQ <= stD;
        end
    end

    assign addrValid = stQ.addrValid;
    assign operandAddr = stQ.operandAddr;
    assign indexedUsed = stQ.indexedUsed;
    assign destMemory = stQ.destMemory;
    assign addValid = stQ.addValid;
    assign addResult = stQ.addResult;
    assign statusFlags = stQ.statusFlags;
    assign addWriteAddr = stQ.addWriteAddr;

    property p_literal_off;
        @(posedge core_clk) disable iff (rst)
        (instrValid && !extEnable && accessBit) |=> (operandAddr == {$past(bankSelector), $past(litArg)});
    endproperty
    a_literal_off: assert property (p_literal_off) else $error("banked address wrong");

    property p_indexed;
        @(posedge core_clk) disable iff (rst)
        (instrValid && extEnable && !accessBit && litArg <= 8'h5F)
            |=> (indexedUsed && operandAddr == $past(indirectPointerTwo) + {4'h0, $past(litArg)});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_all_ops;
        @(posedge core_clk) disable iff (rst)
        (instrValid && extEnable && !accessBit && litArg <= 8'h5F) |=> indexedUsed;
    endproperty
    a_all_ops: assert property (p_all_ops) else $error("opcode escaped indexing");

    property p_zero_ptr;
        @(posedge core_clk) disable iff (rst)
        (instrValid && extEnable && !accessBit && litArg <= 8'h5F && indirectPointerTwo == 12'h000)
            |=> (operandAddr == {4'h0, $past(litArg)});
    endproperty
    a_zero_ptr: assert property (p_zero_ptr) else $error("zero pointer not legacy");

    property p_access_clear;
        @(posedge core_clk) disable iff (rst)
        (instrValid && accessBit) |=> !indexedUsed;
    endproperty
    a_access_clear: assert property (p_access_clear) else $error("indexed with access bit set");

    property p_dest;
        @(posedge core_clk) disable iff (rst)
        instrValid |=> (destMemory == $past(instrWord[9]));
    endproperty
    a_dest: assert property (p_dest) else $error("destination bit lost");

    sequence s_add_issue;
        instrValid && isAddIndexed;
    endsequence
    sequence s_add_done;
        addValid && addResult == $past(accumulator) + $past(memReadData) && addWriteAddr == $past(operandAddr);
    endsequence
    property p_add;
        @(posedge core_clk) disable iff (rst)
        s_add_issue |=> ##1 s_add_done;
    endproperty
    a_add: assert property (p_add) else $error("indexed add result wrong");

    property p_high_literal;
        @(posedge core_clk) disable iff (rst)
        (instrValid && !accessBit && litArg > 8'h5F) |=> (!indexedUsed && operandAddr == {4'hF, $past(litArg)});
    endproperty
    a_high_literal: assert property (p_high_literal) else $error("high access address wrong");

    property p_literal_access;
        @(posedge core_clk) disable iff (rst)
        (instrValid && !extEnable && !accessBit)
            |=> (!indexedUsed && operandAddr == {($past(litArg) < 8'h60) ? 4'h0 : 4'hF, $past(litArg)});
    endproperty
    a_literal_access: assert property (p_literal_access) else $error("access bank address wrong");

    property p_addr_issue;
        @(posedge core_clk) disable iff (rst)
        instrValid |=> addrValid;
    endproperty
    a_addr_issue: assert property (p_addr_issue) else $error("instruction produced no address");

    property p_addr_quiet;
        @(posedge core_clk) disable iff (rst)
        !instrValid |=> !addrValid;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("address strobe without instruction");

    // Flags are held against the operands seen in the cycle before the result strobe
    sequence s_add_carry;
        addValid && {statusFlags[ilo_pkg::FLAG_C], addResult}
            == {1'b0, $past(accumulator)} + {1'b0, $past(memReadData)};
    endsequence
    property p_add_carry;
        @(posedge core_clk) disable iff (rst)
        s_add_issue |=> ##1 s_add_carry;
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    sequence s_add_digit_carry;
        addValid && statusFlags[ilo_pkg::FLAG_DC]
            == ({1'b0, $past(accumulator[3:0])} + {1'b0, $past(memReadData[3:0])} > 5'h0F);
    endsequence
    property p_add_digit_carry;
        @(posedge core_clk) disable iff (rst)
        s_add_issue |=> ##1 s_add_digit_carry;
    endproperty
    a_add_digit_carry: assert property (p_add_digit_carry) else $error("add digit carry wrong");

    sequence s_add_overflow;
        addValid && statusFlags[ilo_pkg::FLAG_OV]
            == ($past(accumulator[7]) == $past(memReadData[7]) && addResult[7] != $past(accumulator[7]));
    endsequence
    property p_add_overflow;
        @(posedge core_clk) disable iff (rst)
        s_add_issue |=> ##1 s_add_overflow;
    endproperty
    a_add_overflow: assert property (p_add_overflow) else $error("add overflow wrong");

    property p_add_zero_neg;
        @(posedge core_clk) disable iff (rst)
        addValid |-> (statusFlags[ilo_pkg::FLAG_Z] == (addResult == 8'h00)
            && statusFlags[ilo_pkg::FLAG_N] == addResult[7]);
    endproperty
    a_add_zero_neg: assert property (p_add_zero_neg) else $error("add zero or negative flag wrong");

    property p_add_only_indexed;
        @(posedge core_clk) disable iff (rst)
        !(instrValid && isAddIndexed) |=> ##1 !addValid;
    endproperty
    a_add_only_indexed: assert property (p_add_only_indexed) else $error("add strobe without indexed add");
endmodule

// >>> dv/ilo_mem_model.sv
// Data memory stand-in that answers operand reads
module ilo_mem_model (
    input wire logic addrValid,
    input wire logic [11:0] operandAddr,
    output logic [7:0] memReadData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pattern;
    assign pattern = operandAddr[7:0] ^ {operandAddr[11:8], 4'hA};
    // Outside the read slot the bus shows the inverse, so stale data cannot pass
    assign memReadData = addrValid ? pattern : ~pattern;
endmodule

// >>> dv/tb.sv
// Self-checking bench for the operand address generator
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic coreClk = 1'b0;
    logic rst = 1'b1;
    logic extEnable = 1'b0;
    logic instrValid = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [3:0] bankSelector = 4'h0;
    logic [11:0] ptr = 12'h000;
    logic [7:0] acc = 8'h00;
    logic [7:0] memData;
    logic addrValid, indexedUsed, destMemory, addValid;
    logic [11:0] operandAddr, addWriteAddr;
    logic [7:0] addResult;
    logic [4:0] statusFlags;
    int failures = 0;
    int comparisons = 0;
    always #50 coreClk = ~coreClk;
    ilo_addr_gen dut (.core_clk(coreClk), .rst(rst), .extEnable(extEnable), .instrValid(instrValid),
        .instrWord(instrWord), .bankSelector(bankSelector), .indirectPointerTwo(ptr), .accumulator(acc),
        .memReadData(memData), .addrValid(addrValid), .operandAddr(operandAddr), .indexedUsed(indexedUsed),
        .destMemory(destMemory), .addValid(addValid), .addResult(addResult), .statusFlags(statusFlags),
        .addWriteAddr(addWriteAddr));
    ilo_mem_model mem (.addrValid(addrValid), .operandAddr(operandAddr), .memReadData(memData));
    task automatic finish_test();
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chkv(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chkv({11'h000, got}, {11'h000, exp});
    endtask
    function automatic logic [11:0] exp_addr(input logic [15:0] w, input logic [3:0] b, input logic [11:0] p);
        if (w[8]) return {b, w[7:0]};
        if (extEnable && w[7:0] <= 8'h5F) return p + {4'h0, w[7:0]};
        return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
    endfunction
    // Back-to-back instructions; add results are left to the design's own assertions
    task automatic run_burst(input int n);
        logic [15:0] w;
        logic [11:0] p;
        logic [3:0] b;
        logic [11:0] expQ[$];
        for (int k = 0; k <= n; k++) begin
            if (k < n) begin
                w = 16'($urandom);
                b = 4'($urandom);
                p = 12'($urandom);
                if (k % 3 != 2) w[8] = 1'b0;
                if (k % 4 < 2) w[15:10] = 6'h09;
                if (k % 2 == 0) w[7:0] = 8'(k);
                expQ.push_back(exp_addr(w, b, p));
                instrValid <= 1'b1;
                instrWord <= w;
                bankSelector <= b;
                ptr <= p;
                acc <= 8'($urandom);
            end else begin
                instrValid <= 1'b0;
            end
            if (k > 0) begin
                #1;
                chkb(addrValid, 1'b1);
                chkv(operandAddr, expQ.pop_front());
            end
            @(posedge coreClk);
        end
    endtask
    task automatic run_one(input int i);
        logic [15:0] w;
        logic [11:0] ea, p;
        logic [7:0] a, m;
        logic [3:0] b;
        logic idx, isAdd;
        int s;
        w = 16'($urandom);
        b = 4'($urandom);
        a = 8'($urandom);
        p = (i % 5 == 0) ? 12'h000 : 12'($urandom);
        if (i % 4 < 2) w[7:0] = 8'h5F + 8'(i % 2);
        if (i % 2 == 0) w[15:10] = 6'h09;
        if (i % 3 != 0) w[8] = 1'b0;
        idx = extEnable && !w[8] && w[7:0] <= 8'h5F;
        if (w[8]) ea = {b, w[7:0]};
        else if (idx) ea = p + {4'h0, w[7:0]};
        else ea = {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
        isAdd = idx && w[15:10] == 6'h09;
        m = ea[7:0] ^ {ea[11:8], 4'hA};
        s = int'(a) + int'(m);
        instrValid <= 1'b1;
        instrWord <= w;
        bankSelector <= b;
        ptr <= p;
        acc <= a;
        @(posedge coreClk);
        instrValid <= 1'b0;
        #1;
        chkb(addrValid, 1'b1);
        chkv(operandAddr, ea);
        if (idx && p == 12'h000) chkv(operandAddr, {4'h0, w[7:0]});
        chkb(indexedUsed, idx);
        chkb(destMemory, w[9]);
        @(posedge coreClk);
        #1;
        chkb(addValid, isAdd);
        if (isAdd) begin
            chkv({4'h0, addResult}, 12'(s[7:0]));
            chkv({7'h00, statusFlags}, {7'h00, s[7], a[7] == m[7] && s[7] != a[7], s[7:0] == 0,
                (a[3:0] + m[3:0]) > 15 ? 1'b1 : 1'b0, s > 255 ? 1'b1 : 1'b0});
            chkv(addWriteAddr, ea);
        end
        @(posedge coreClk);
    endtask
    initial begin
        void'($urandom(32'h75C1));
        // The extension is static, so it only changes under reset
        for (int e = 0; e < 2; e++) begin
            rst <= 1'b1;
            extEnable <= e[0];
            repeat (2) @(posedge coreClk);
            rst <= 1'b0;
            for (int i = 0; i < 150; i++) run_one(i);
            run_burst(40);
        end
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge coreClk);
        failures++;
        finish_test();
    end
endmodule
